/* File: rtl/phyx_regs.sv */
// Extended control, interrupt and cable-diagnostic registers of a 10/100 PHY.
// Assumes all inputs are synchronous to clk; events and test done are one-cycle pulses.
// How it works
// - energy-detect power-down off bit, resets one
// - latency bit selects random MII receive latency
// - 100Base-TX passes every preamble nibble
// - 10Base-T strips preamble unless restore set
// - eight enable bits, upper byte, reset zero
// - event flags in lower byte, same order
// - flags read-only, clear on read, reset zero
// - interrupt polarity follows level-select input
// - writing one starts test, self-clears on done
// - two-bit result field, resets to normal
// - short-cable bit under ten metres
`timescale 1ns/1ps
`default_nettype none
module phyx_regs
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [4:0]  phy_addr,
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  input  wire logic [7:0]  evt,
  input  wire logic        int_active_high,
  output logic             irq_pin,
  output logic             energy_detect_powerdown_dis,
  output logic             rx_latency_random,
  input  wire logic        speed_10,
  input  wire logic        rx_dv_in,
  input  wire logic [3:0]  rxd_in,
  output logic             rx_dv,
  output logic [3:0]       rxd,
  output logic             cable_test_run,
  input  wire logic        cable_test_done,
  input  wire logic [1:0]  cable_test_result,
  input  wire logic        cable_test_short,
  input  wire logic [8:0]  cable_test_distance
);
  logic [4:0]  reg_addr;
  logic        rd_stb;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  phyx_mdio u_mdio
  (
    .clk      (clk),
    .nrst     (nrst),
    .phy_addr (phy_addr),
    .mdc      (mdc),
    .mdio_i   (mdio_i),
    .mdio_o   (mdio_o),
    .mdio_oe  (mdio_oe),
    .reg_addr (reg_addr),
    .rd_stb   (rd_stb),
    .rd_data  (rd_data),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data)
  );

  // ==========================================================
  // Expanded receive control
  logic [15:0] exp_ctrl;
  logic        wr_exp;
  logic        wr_int;
  logic        wr_diag;
  logic        rd_int;

  assign wr_exp  = wr_stb && reg_addr == phyx_pkg::REG_EXP_CTRL;
  assign wr_int  = wr_stb && reg_addr == phyx_pkg::REG_INT_CTRL;
  assign wr_diag = wr_stb && reg_addr == phyx_pkg::REG_DIAG;
  assign rd_int  = rd_stb && reg_addr == phyx_pkg::REG_INT_CTRL;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      exp_ctrl <= phyx_pkg::EXP_CTRL_RESET;
    else if (wr_exp)
      exp_ctrl <= wr_data;
  end

  assign energy_detect_powerdown_dis = exp_ctrl[phyx_pkg::EXP_PWRDN_OFF_BIT];
  assign rx_latency_random           = exp_ctrl[phyx_pkg::EXP_LATENCY_BIT];

  // ==========================================================
  // Receive preamble filter
  logic       strip;
  logic       pass;
  logic       hit;
  logic       dv1;
  logic [3:0] d1;

  assign strip = speed_10 & ~exp_ctrl[phyx_pkg::EXP_PRE_RESTORE_BIT];
  assign hit   = strip & rx_dv_in & ~pass & (rxd_in == phyx_pkg::NIB_SFD);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pass  <= 1'b0;
      dv1   <= 1'b0;
      d1    <= 4'h0;
      rx_dv <= 1'b0;
      rxd   <= 4'h0;
    end
    else
    begin
      dv1 <= rx_dv_in;
      d1  <= rxd_in;
      rxd <= d1;
      if (!rx_dv_in)
        pass <= 1'b0;
      else if (hit)
        pass <= 1'b1;
      // Held nibble is the first SFD nibble when the closing one arrives
      rx_dv <= dv1 & (~strip | pass | hit);
    end
  end

  // ==========================================================
  // Interrupt enables, flags and pin
  logic [7:0] int_en;
  logic [7:0] int_flag;
  logic [7:0] next_int_flag;
  logic       irq_any;

  assign next_int_flag = (int_flag & ~{8{rd_int}}) | evt;
  assign irq_any       = |(int_flag & int_en);

  always_ff @(posedge clk)
  begin
    if (!nrst)
      int_en <= phyx_pkg::INT_EN_RESET;
    else if (wr_int)
      int_en <= wr_data[phyx_pkg::INT_EN_LSB +: 8];
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      int_flag <= phyx_pkg::INT_FLAG_RESET;
    else
      int_flag <= next_int_flag;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      irq_pin <= 1'b1;
    else
      irq_pin <= irq_any ~^ int_active_high;
  end

  // ==========================================================
  // Cable diagnostic
  logic [1:0] diag_result;
  logic       diag_short;
  logic [2:0] diag_rsvd;
  logic [8:0] diag_dist;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cable_test_run <= 1'b0;
      diag_result    <= phyx_pkg::DIAG_RESULT_RESET;
      diag_short     <= 1'b0;
      diag_rsvd      <= phyx_pkg::DIAG_RSVD_RESET;
      diag_dist      <= phyx_pkg::DIAG_DIST_RESET;
    end
    else
    begin
      if (wr_diag)
      begin
        cable_test_run <= wr_data[phyx_pkg::DIAG_RUN_BIT];
        diag_rsvd      <= wr_data[phyx_pkg::DIAG_RSVD_LSB +: 3];
      end
      else if (cable_test_done && cable_test_run)
        cable_test_run <= 1'b0;
      if (cable_test_done && cable_test_run)
      begin
        diag_result <= cable_test_result;
        diag_short  <= cable_test_short;
        diag_dist   <= cable_test_distance;
      end
    end
  end

  // ==========================================================
  // Read data
  always_comb
  begin
    unique case (reg_addr)
      phyx_pkg::REG_EXP_CTRL: rd_data = exp_ctrl;
      phyx_pkg::REG_INT_CTRL: rd_data = {int_en, int_flag};
      phyx_pkg::REG_DIAG:     rd_data = {cable_test_run, diag_result, diag_short, diag_rsvd, diag_dist};
      default:                rd_data = 16'h0000;
    endcase
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_pwrdn_write: assert property (wr_exp |=> energy_detect_powerdown_dis == $past(wr_data[11]))
    else $error("power-down bit did not follow write");
  chk_latency_write: assert property (wr_exp |=> rx_latency_random == $past(wr_data[10]))
    else $error("latency bit did not follow write");
  chk_pass_all: assert property (rx_dv_in && !strip ##1 !strip |=> rx_dv)
    else $error("preamble nibble dropped");
  chk_pre_strip: assert property (strip && dv1 && !pass && !hit |=> !rx_dv)
    else $error("preamble not stripped");
  chk_en_write: assert property (wr_int |=> int_en == $past(wr_data[15:8]))
    else $error("enable byte not stored");
  chk_event_set: assert property (|evt |=> (int_flag & $past(evt)) == $past(evt))
    else $error("event flag not set");
  chk_flag_clear: assert property (rd_int && evt == 8'h00 |=> int_flag == 8'h00)
    else $error("flags not cleared by read");
  chk_irq_level: assert property (nrst |=> irq_pin == ($past(irq_any) ~^ $past(int_active_high)))
    else $error("interrupt pin level wrong");
  chk_test_done: assert property (cable_test_done && cable_test_run && !wr_diag |=>
    !cable_test_run && diag_result == $past(cable_test_result) && diag_short == $past(cable_test_short)
    && diag_dist == $past(cable_test_distance))
    else $error("test completion not recorded");
  chk_result_hold: assert property (!cable_test_done |=> $stable(diag_result) && $stable(diag_short))
    else $error("result changed without completion");

  cov_test_done: cover property (cable_test_run ##[1:20] !cable_test_run);
  cov_int_read: cover property (rd_int && int_flag != 8'h00);
  cov_sfd_hit: cover property (hit ##1 rx_dv);
  cov_irq_on: cover property (irq_any);
endmodule : phyx_regs
`default_nettype wire

/* File: rtl/phyx_pkg.sv */
// Constants for the extended management register bank of a 10/100 PHY.
// Assumes the user writes phyx_pkg::name everywhere and imports nothing.
`default_nettype none
package phyx_pkg;
  // ==========================================================
  // Register addresses on the management bus
  localparam logic [4:0]  REG_EXP_CTRL        = 5'h18;
  localparam logic [4:0]  REG_INT_CTRL        = 5'h1b;
  localparam logic [4:0]  REG_DIAG            = 5'h1d;

  // ==========================================================
  // Reset values
  localparam logic [15:0] EXP_CTRL_RESET      = 16'h0800;
  localparam logic [7:0]  INT_EN_RESET        = 8'h00;
  localparam logic [7:0]  INT_FLAG_RESET      = 8'h00;
  localparam logic [1:0]  DIAG_RESULT_RESET   = 2'h0;
  localparam logic [8:0]  DIAG_DIST_RESET     = 9'h000;
  localparam logic [2:0]  DIAG_RSVD_RESET     = 3'h0;

  // ==========================================================
  // Field positions
  localparam int          EXP_PWRDN_OFF_BIT   = 11;
  localparam int          EXP_LATENCY_BIT     = 10;
  localparam int          EXP_PRE_RESTORE_BIT = 6;
  localparam int          INT_EN_LSB          = 8;
  localparam int          INT_FLAG_LSB        = 0;
  localparam int          DIAG_RUN_BIT        = 15;
  localparam int          DIAG_RESULT_LSB     = 13;
  localparam int          DIAG_SHORT_BIT      = 12;
  localparam int          DIAG_RSVD_LSB       = 9;
  localparam int          DIAG_DIST_LSB       = 0;

  // ==========================================================
  // Management frame layout
  localparam logic [5:0]  MDIO_PREAMBLE_LEN   = 6'h20;
  localparam logic [4:0]  MDIO_HDR_LAST       = 5'h0c;
  localparam logic [4:0]  MDIO_DATA_LAST      = 5'h0f;
  localparam logic [1:0]  MDIO_OP_READ        = 2'h2;
  localparam logic [1:0]  MDIO_OP_WRITE       = 2'h1;

  // Receive nibble that closes the start-of-frame delimiter
  localparam logic [3:0]  NIB_SFD             = 4'hd;

  typedef enum logic [4:0] {
    PHYX_IDLE = 5'b00001,
    PHYX_HDR  = 5'b00010,
    PHYX_TA   = 5'b00100,
    PHYX_DATA = 5'b01000,
    PHYX_SPARE = 5'b10000
  } phyx_mdio_state_t;
endpackage : phyx_pkg
`default_nettype wire

/* File: rtl/phyx_mdio.sv */
// Management frame slave: decodes read and write frames clocked by mdc.
// Assumes mdc and mdio_i are synchronous to clk and mdc is slower than clk/2.
`timescale 1ns/1ps
`default_nettype none
module phyx_mdio
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [4:0]  phy_addr,
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  output logic [4:0]       reg_addr,
  output logic             rd_stb,
  input  wire logic [15:0] rd_data,
  output logic             wr_stb,
  output logic [15:0]      wr_data
);
  // ==========================================================
  // Frame decoder
  phyx_pkg::phyx_mdio_state_t state;
  logic        mdc_q;
  logic [5:0]  ones;
  logic [4:0]  cnt;
  logic [15:0] shift;
  logic        is_read;
  logic [12:0] hdr;
  logic        rise;

  assign rise = mdc & ~mdc_q;
  assign hdr  = {shift[11:0], mdio_i};

  always_ff @(posedge clk)
  begin
    if (!nrst)
      mdc_q <= 1'b0;
    else
      mdc_q <= mdc;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state    <= phyx_pkg::PHYX_IDLE;
      ones     <= 6'h00;
      cnt      <= 5'h00;
      shift    <= 16'h0000;
      is_read  <= 1'b0;
      reg_addr <= 5'h00;
      mdio_o   <= 1'b0;
      mdio_oe  <= 1'b0;
      rd_stb   <= 1'b0;
      wr_stb   <= 1'b0;
      wr_data  <= 16'h0000;
    end
    else
    begin
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
      if (rise)
      begin
        unique case (state)
          phyx_pkg::PHYX_IDLE:
          begin
            if (mdio_i)
              ones <= (ones == phyx_pkg::MDIO_PREAMBLE_LEN) ? ones : ones + 6'h01;
            else
            begin
              ones <= 6'h00;
              cnt  <= 5'h00;
              if (ones == phyx_pkg::MDIO_PREAMBLE_LEN)
                state <= phyx_pkg::PHYX_HDR;
            end
          end
          phyx_pkg::PHYX_HDR:
          begin
            shift <= {shift[14:0], mdio_i};
            cnt   <= cnt + 5'h01;
            if (cnt == phyx_pkg::MDIO_HDR_LAST)
            begin
              cnt <= 5'h00;
              // Start bit, own address and a legal opcode
              if (hdr[12] && hdr[9:5] == phy_addr &&
                  (hdr[11:10] == phyx_pkg::MDIO_OP_READ || hdr[11:10] == phyx_pkg::MDIO_OP_WRITE))
              begin
                state    <= phyx_pkg::PHYX_TA;
                reg_addr <= hdr[4:0];
                is_read  <= (hdr[11:10] == phyx_pkg::MDIO_OP_READ);
              end
              else
                state <= phyx_pkg::PHYX_IDLE;
            end
          end
          phyx_pkg::PHYX_TA:
          begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'h00)
            begin
              // Capture and read strobe share this edge; read side effects land one clk later
              if (is_read)
              begin
                shift   <= rd_data;
                rd_stb  <= 1'b1;
                mdio_oe <= 1'b1;
                mdio_o  <= 1'b0;
              end
            end
            else
            begin
              cnt   <= 5'h00;
              state <= phyx_pkg::PHYX_DATA;
              if (is_read)
              begin
                mdio_o <= shift[15];
                shift  <= {shift[14:0], 1'b0};
              end
            end
          end
          phyx_pkg::PHYX_DATA:
          begin
            cnt <= cnt + 5'h01;
            if (is_read)
            begin
              mdio_o <= shift[15];
              shift  <= {shift[14:0], 1'b0};
            end
            else
              shift <= {shift[14:0], mdio_i};
            if (cnt == phyx_pkg::MDIO_DATA_LAST)
            begin
              state   <= phyx_pkg::PHYX_IDLE;
              mdio_oe <= 1'b0;
              cnt     <= 5'h00;
              if (!is_read)
              begin
                wr_stb  <= 1'b1;
                wr_data <= {shift[14:0], mdio_i};
              end
            end
          end
          default:
            state <= phyx_pkg::PHYX_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  chk_rd_drive: assert property (@(posedge clk) disable iff (!nrst)
    rd_stb |=> mdio_oe && !mdio_o)
    else $error("read turnaround not driven low");
endmodule : phyx_mdio
`default_nettype wire

/* File: dv/phyx_mgmt_model.sv */
// Station management controller model that runs read and write frames on mdc/mdio.
// Assumes clk is the device clock; mdio is pulled up whenever nobody drives it.
`timescale 1ns/1ps
`default_nettype none
module phyx_mgmt_model
(
  input  wire logic clk,
  output logic      mdc,
  output logic      mdio_i,
  input  wire logic mdio_o,
  input  wire logic mdio_oe
);
  logic drv;
  logic bit_q;

  // Wire level: device first, then this host, else the pull-up
  assign mdio_i = mdio_oe ? mdio_o : (drv ? bit_q : 1'b1);

  initial
  begin
    mdc = 1'b0;
    drv = 1'b0;
    bit_q = 1'b0;
  end

  // ===========================================
  // Bus cycles
  // One mdc period of eight clk; the wire is sampled just before the rise
  task automatic tick(input logic d, input logic en, output logic s);
    @(negedge clk);
    drv = en;
    bit_q = d;
    mdc = 1'b0;
    repeat (4) @(negedge clk);
    s = mdio_i;
    mdc = 1'b1;
    repeat (3) @(negedge clk);
  endtask : tick

  // Host releases the line through the turnaround and data of a read
  task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] q);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, rd ? phyx_pkg::MDIO_OP_READ : phyx_pkg::MDIO_OP_WRITE, pa, ra};
    repeat (32) tick(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) tick(hdr[i], 1'b1, s);
    tick(1'b1, !rd, s);
    tick(1'b0, !rd, s);
    for (int i = 15; i >= 0; i--)
    begin
      tick(wd[i], !rd, s);
      q[i] = s;
    end
    @(negedge clk);
    mdc = 1'b0;
    drv = 1'b0;
    repeat (4) @(negedge clk);
  endtask : xfer
endmodule : phyx_mgmt_model
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the extended management register bank.
// Assumes phyx_mgmt_model as the far side and a 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [4:0] ADDR = 5'h03;
  logic        clk, nrst, mdc, mdio_i, mdio_o, mdio_oe, int_active_high, irq_pin;
  logic        energy_detect_powerdown_dis, rx_latency_random, speed_10, rx_dv_in, rx_dv;
  logic        cable_test_run, cable_test_done, cable_test_short;
  logic [1:0]  cable_test_result;
  logic [3:0]  rxd_in, rxd;
  logic [8:0]  cable_test_distance;
  logic [7:0]  evt, en, ev;
  logic [15:0] q, w;
  logic [3:0]  seen[$];
  logic [3:0]  want[$];
  int          n_errors, checks, cycles;

  phyx_regs i_dut
  (
    .clk(clk), .nrst(nrst), .phy_addr(ADDR), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .evt(evt), .int_active_high(int_active_high), .irq_pin(irq_pin),
    .energy_detect_powerdown_dis(energy_detect_powerdown_dis), .rx_latency_random(rx_latency_random),
    .speed_10(speed_10), .rx_dv_in(rx_dv_in), .rxd_in(rxd_in), .rx_dv(rx_dv), .rxd(rxd),
    .cable_test_run(cable_test_run), .cable_test_done(cable_test_done),
    .cable_test_result(cable_test_result), .cable_test_short(cable_test_short),
    .cable_test_distance(cable_test_distance)
  );

  phyx_mgmt_model i_mgmt
  (
    .clk(clk), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe)
  );

  always #4 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rx_dv === 1'b1)
      seen.push_back(rxd);
    if (cycles == 60000)
    begin
      n_errors++;
      summarize();
    end
  end

  // ===========================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic rd(input logic [4:0] ra);
    i_mgmt.xfer(1'b1, ADDR, ra, 16'h0000, q);
  endtask : rd

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    i_mgmt.xfer(1'b0, ADDR, ra, d, q);
  endtask : wr

  function automatic logic [15:0] irq_exp(input logic [7:0] e, input logic [7:0] f, input logic hi);
    return {15'h0000, hi ? |(e & f) : !(|(e & f))};
  endfunction : irq_exp

  // ===========================================
  // Main sequence
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    evt = 8'h00;
    int_active_high = 1'b0;
    speed_10 = 1'b0;
    rx_dv_in = 1'b0;
    rxd_in = 4'h0;
    cable_test_done = 1'b0;
    cable_test_result = 2'h0;
    cable_test_short = 1'b0;
    cable_test_distance = 9'h000;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    void'($urandom(93));
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    chk("irq idle", 16'h0001, {15'h0000, irq_pin});
    chk("pwrdn out", 16'h0001, {15'h0000, energy_detect_powerdown_dis});
    rd(phyx_pkg::REG_EXP_CTRL);
    chk("reg 18 reset", 16'h0800, q);
    rd(phyx_pkg::REG_INT_CTRL);
    chk("reg 1b reset", 16'h0000, q);
    rd(phyx_pkg::REG_DIAG);
    chk("reg 1d reset", 16'h0000, q);
    rd(5'h19);
    chk("unmapped", 16'h0000, q);
    i_mgmt.xfer(1'b1, ADDR ^ 5'h01, phyx_pkg::REG_EXP_CTRL, 16'h0000, q);
    chk("foreign addr", 16'hffff, q);
    for (int i = 0; i < 4; i++)
    begin
      w = (i == 0) ? 16'h0000 : 16'($urandom);
      wr(phyx_pkg::REG_EXP_CTRL, w);
      rd(phyx_pkg::REG_EXP_CTRL);
      chk("reg 18", w, q);
      chk("ctl outs", {14'h0000, w[11:10]}, {14'h0000, energy_detect_powerdown_dis, rx_latency_random});
    end
    for (int i = 0; i < 8; i++)
    begin
      int_active_high = i[0];
      en = 8'($urandom);
      ev = 8'($urandom) | (8'h01 << i);
      if (i == 7)
        en = ~ev;
      wr(phyx_pkg::REG_INT_CTRL, {en, 8'hff});
      @(negedge clk);
      evt = ev;
      @(negedge clk);
      evt = 8'h00;
      repeat (3) @(negedge clk);
      chk("irq set", irq_exp(en, ev, i[0]), {15'h0000, irq_pin});
      rd(phyx_pkg::REG_INT_CTRL);
      chk("reg 1b", {en, ev}, q);
      chk("irq clr", irq_exp(en, 8'h00, i[0]), {15'h0000, irq_pin});
      rd(phyx_pkg::REG_INT_CTRL);
      chk("reg 1b clr", {en, 8'h00}, q);
    end
    for (int i = 0; i < 4; i++)
    begin
      w = 16'h8000 | 16'($urandom);
      wr(phyx_pkg::REG_DIAG, w);
      chk("run", 16'h0001, {15'h0000, cable_test_run});
      rd(phyx_pkg::REG_DIAG);
      chk("run bit", 16'h0001, {15'h0000, q[15]});
      @(negedge clk);
      cable_test_result = 2'(i);
      cable_test_short = 1'($urandom);
      cable_test_distance = 9'($urandom);
      cable_test_done = 1'b1;
      @(negedge clk);
      cable_test_done = 1'b0;
      repeat (2) @(negedge clk);
      chk("run done", 16'h0000, {15'h0000, cable_test_run});
      rd(phyx_pkg::REG_DIAG);
      chk("reg 1d", {1'b0, cable_test_result, cable_test_short, w[11:9], cable_test_distance}, q);
    end
    for (int m = 0; m < 3; m++)
    begin
      speed_10 = (m != 2);
      wr(phyx_pkg::REG_EXP_CTRL, {9'h000, m == 1, 6'h00});
      seen.delete();
      want.delete();
      for (int k = 0; k < 24; k++)
      begin
        @(negedge clk);
        rx_dv_in = 1'b1;
        rxd_in = (k < 15) ? 4'h5 : (k == 15) ? 4'hd : 4'($urandom);
        if (k >= 14 || m != 0)
          want.push_back(rxd_in);
      end
      @(negedge clk);
      rx_dv_in = 1'b0;
      rxd_in = ~rxd_in;
      repeat (4) @(negedge clk);
      chk("mii count", 16'(want.size()), 16'(seen.size()));
      foreach (want[j])
        chk("mii nibble", {12'h000, want[j]}, {12'h000, seen[j]});
    end
    summarize();
  end
endmodule : testbench
`default_nettype wire
